// ==== hw/pmia_regs.sv ====
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// RULE_01 - control bits 4:0 hold the extended device address used by accesses.
// RULE_02 - control bits 15:14 hold the operation; 00 means address mode.
// RULE_03 - operation 11: data port, address advances after writes only.
// RULE_04 - operation 01: data, no advance; operation 10: advance on reads and writes.
// RULE_05 - operation 00: companion register reads and writes the target address.
// RULE_06 - non-zero operation: companion register moves the addressed register's data.
// RULE_07 - status bit 15 reads 0: no 1000BASE-X full duplex.
// RULE_08 - status bit 14 reads 0: no 1000BASE-X half duplex.
// RULE_09 - status bit 13 reads 1: 1000BASE-T full duplex supported.
// RULE_10 - software sets device and address mode, writes address, then switches to data.
// RULE_11 - each post-increment adds exactly one after the qualifying access.
module pmia_regs #(
   parameter int         DEV_BITS   = 2,
   parameter int         REG_BITS   = 3,
   parameter logic       T_HD_CAP   = 1'b0
) (
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   input  wire logic [pmia_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [pmia_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [4:0]                      dev;
      logic [1:0]                      op;
      logic [8:0]                      rsvd;
      logic [15:0]                     addr;
      logic                            aw_got;
      logic [pmia_pkg::AXI_ADDR_W-1:0] awaddr;
      logic                            w_got;
      logic [15:0]                     wdata;
      logic [1:0]                      wstrb;
      logic                            bvalid;
      logic [1:0]                      bresp;
      logic                            rvalid;
      logic [15:0]                     rdata;
      logic [1:0]                      rresp;
   } pmia_state_type;

   pmia_state_type            st_ff;
   pmia_state_type            nxt_st;
   pmia_pkg::pmia_ext_wr_type ext_wr;
   pmia_pkg::pmia_ext_rd_type ext_rd;
   logic [15:0]               ext_rdata;
   logic [15:0]               ctrl_word;
   logic [15:0]               status_word;

   function automatic pmia_pkg::pmia_sel_type decode(
      input logic [pmia_pkg::AXI_ADDR_W-1:0] a
   );
      pmia_pkg::pmia_sel_type s;
      s = pmia_pkg::PMIA_SEL_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[7:2])
            pmia_pkg::IDX_CTRL:   s = pmia_pkg::PMIA_SEL_CTRL;
            pmia_pkg::IDX_DATA:   s = pmia_pkg::PMIA_SEL_DATA;
            pmia_pkg::IDX_STATUS: s = pmia_pkg::PMIA_SEL_STATUS;
            default:              s = pmia_pkg::PMIA_SEL_NONE;
         endcase
      end
      return s;
   endfunction

   // only byte lanes 0 and 1 carry register bits
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] wd,
      input logic [1:0]  strb
   );
      return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
   endfunction

   assign ctrl_word = {st_ff.op, st_ff.rsvd, st_ff.dev};

   always_comb begin
      status_word                    = 16'h0000;
      status_word[pmia_pkg::ST_X_FD] = 1'b0;  // RULE_07
      status_word[pmia_pkg::ST_X_HD] = 1'b0;  // RULE_08
      status_word[pmia_pkg::ST_T_FD] = 1'b1;  // RULE_09
      status_word[pmia_pkg::ST_T_HD] = T_HD_CAP;
   end

   // ************************************************************
   // extended register store
   // ************************************************************
   assign ext_rd.dev  = st_ff.dev;   // RULE_01
   assign ext_rd.addr = st_ff.addr;

   pmia_ext_store #(
      .DEV_BITS (DEV_BITS),
      .REG_BITS (REG_BITS)
   ) u_store (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr      (ext_wr),
      .rd      (ext_rd),
      .rdata   (ext_rdata)
   );

   // ************************************************************
   // bus handshakes
   // ************************************************************
   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rresp   = st_ff.rresp;
   assign s_axi_rdata   = {16'h0000, st_ff.rdata};

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic                            aw_ok;
      logic                            w_ok;
      logic [pmia_pkg::AXI_ADDR_W-1:0] wa;
      logic [15:0]                     wd;
      logic [1:0]                      ws;
      logic                            do_wr;
      logic                            do_rd;
      logic                            rd_inc;
      logic                            wr_inc;
      pmia_pkg::pmia_sel_type          wsel;
      pmia_pkg::pmia_sel_type          rsel;
      logic [15:0]                     cw;
      nxt_st = st_ff;
      ext_wr = '0;
      aw_ok  = st_ff.aw_got || (s_axi_awvalid && s_axi_awready);
      w_ok   = st_ff.w_got || (s_axi_wvalid && s_axi_wready);
      wa     = st_ff.aw_got ? st_ff.awaddr : s_axi_awaddr;
      wd     = st_ff.w_got ? st_ff.wdata : s_axi_wdata[15:0];
      ws     = st_ff.w_got ? st_ff.wstrb : s_axi_wstrb[1:0];
      cw     = merge(ctrl_word, wd, ws);
      do_wr  = aw_ok && w_ok;
      do_rd  = s_axi_arvalid && s_axi_arready;
      wsel   = decode(wa);
      rsel   = decode(s_axi_araddr);
      rd_inc = 1'b0;
      wr_inc = 1'b0;

      if (s_axi_bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end

      // address and data may arrive in either order; park whichever comes first
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata[15:0];
         nxt_st.wstrb = s_axi_wstrb[1:0];
      end

      if (do_rd) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = pmia_pkg::RESP_OKAY;
         case (rsel)
            pmia_pkg::PMIA_SEL_CTRL:   nxt_st.rdata = ctrl_word;
            pmia_pkg::PMIA_SEL_STATUS: nxt_st.rdata = status_word;
            pmia_pkg::PMIA_SEL_DATA: begin
               if (st_ff.op == pmia_pkg::PMIA_OP_REG) begin
                  nxt_st.rdata = st_ff.addr;  // RULE_05
               end else begin
                  nxt_st.rdata = ext_rdata;  // RULE_06
               end
               rd_inc = (st_ff.op == pmia_pkg::PMIA_OP_DATA_INC);  // RULE_04
            end
            default: begin
               nxt_st.rdata = 16'h0000;
               nxt_st.rresp = pmia_pkg::RESP_SLVERR;
            end
         endcase
      end

      if (do_wr) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = pmia_pkg::RESP_OKAY;
         case (wsel)
            pmia_pkg::PMIA_SEL_CTRL: begin
               nxt_st.dev  = cw[pmia_pkg::DEV_MSB:pmia_pkg::DEV_LSB];  // RULE_01
               nxt_st.rsvd = cw[pmia_pkg::RSVD_MSB:pmia_pkg::RSVD_LSB];
               nxt_st.op   = cw[pmia_pkg::OP_MSB:pmia_pkg::OP_LSB];  // RULE_02
            end
            pmia_pkg::PMIA_SEL_DATA: begin
               if (st_ff.op == pmia_pkg::PMIA_OP_REG) begin
                  nxt_st.addr = merge(st_ff.addr, wd, ws);  // RULE_05
               end else begin
                  ext_wr.we   = 1'b1;  // RULE_06
                  ext_wr.dev  = st_ff.dev;
                  ext_wr.addr = st_ff.addr;
                  ext_wr.data = merge(ext_rdata, wd, ws);
                  wr_inc      = 1'b1;  // RULE_03 RULE_04
                  if (st_ff.op == pmia_pkg::PMIA_OP_DATA) begin
                     wr_inc = 1'b0;  // RULE_04
                  end
               end
            end
            pmia_pkg::PMIA_SEL_STATUS: begin
               // read-only: write accepted and dropped
               nxt_st.bresp = pmia_pkg::RESP_OKAY;
            end
            default: nxt_st.bresp = pmia_pkg::RESP_SLVERR;
         endcase
      end

      // a read and a write in one cycle each advance once
      nxt_st.addr = nxt_st.addr + {15'h0000, rd_inc} + {15'h0000, wr_inc};  // RULE_11
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff      <= '0;
         st_ff.dev  <= pmia_pkg::DEV_RESET;
         st_ff.rsvd <= pmia_pkg::RSVD_RESET;
         st_ff.addr <= pmia_pkg::ADDR_RESET;
         st_ff.op   <= pmia_pkg::PMIA_OP_REG;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

// ==== hw/pmia_pkg.sv ====
package pmia_pkg;

   // ************************************************************
   // bus geometry
   // ************************************************************
   localparam int          AXI_ADDR_W  = 8;
   localparam int          AXI_DATA_W  = 32;
   localparam int          REG_W       = 16;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ************************************************************
   // register indices; byte address is four times the index
   // ************************************************************
   localparam logic [5:0]  IDX_CTRL    = 6'h0d;
   localparam logic [5:0]  IDX_DATA    = 6'h0e;
   localparam logic [5:0]  IDX_STATUS  = 6'h0f;

   // ************************************************************
   // access control field layout and reset values
   // ************************************************************
   localparam int          OP_MSB      = 15;
   localparam int          OP_LSB      = 14;
   localparam int          RSVD_MSB    = 13;
   localparam int          RSVD_LSB    = 5;
   localparam int          DEV_MSB     = 4;
   localparam int          DEV_LSB     = 0;
   localparam logic [4:0]  DEV_RESET   = 5'h00;
   localparam logic [8:0]  RSVD_RESET  = 9'h000;
   localparam logic [15:0] ADDR_RESET  = 16'h0000;

   typedef enum logic [1:0] {
      PMIA_OP_REG      = 2'h0,
      PMIA_OP_DATA     = 2'h1,
      PMIA_OP_DATA_INC = 2'h2,
      PMIA_OP_DATA_WR  = 2'h3
   } pmia_op_type;

   // ************************************************************
   // extended status bits
   // ************************************************************
   localparam int          ST_X_FD     = 15;
   localparam int          ST_X_HD     = 14;
   localparam int          ST_T_FD     = 13;
   localparam int          ST_T_HD     = 12;

   typedef enum logic [1:0] {
      PMIA_SEL_CTRL,
      PMIA_SEL_DATA,
      PMIA_SEL_STATUS,
      PMIA_SEL_NONE
   } pmia_sel_type;

   // write request into the extended register store
   typedef struct packed {
      logic        we;
      logic [4:0]  dev;
      logic [15:0] addr;
      logic [15:0] data;
   } pmia_ext_wr_type;

   // read lookup into the extended register store
   typedef struct packed {
      logic [4:0]  dev;
      logic [15:0] addr;
   } pmia_ext_rd_type;

endpackage

// ==== hw/pmia_ext_store.sv ====
`timescale 1ns/1ps
// small flip-flop model of the extended register spaces; only the low
// dev_bits of the device and low reg_bits of the register address index it
module pmia_ext_store #(
   parameter int DEV_BITS = 2,
   parameter int REG_BITS = 3
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire pmia_pkg::pmia_ext_wr_type wr,
   input  wire pmia_pkg::pmia_ext_rd_type rd,
   output logic [15:0]                    rdata
);

   localparam int DEPTH = 1 << (DEV_BITS + REG_BITS);

   typedef struct packed {
      logic [DEPTH-1:0][15:0] mem;
   } pmia_store_state_type;

   pmia_store_state_type st_ff;
   pmia_store_state_type nxt_st;

   logic [DEV_BITS+REG_BITS-1:0] widx;
   logic [DEV_BITS+REG_BITS-1:0] ridx;

   assign widx  = {wr.dev[DEV_BITS-1:0], wr.addr[REG_BITS-1:0]};
   assign ridx  = {rd.dev[DEV_BITS-1:0], rd.addr[REG_BITS-1:0]};
   assign rdata = st_ff.mem[ridx];

   always_comb begin
      nxt_st = st_ff;
      if (wr.we) begin
         nxt_st.mem[widx] = wr.data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

// ==== dv/pmia_regs_monitor.sv ====
`timescale 1ns/1ps
// ************************************************************
// bus handshake and status checks
// ************************************************************
module pmia_regs_monitor #(
   parameter logic T_HD_CAP = 1'b0
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_st_take;
      s_rd_take ##0 s_axi_araddr == 8'h3c;
   endsequence
   a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read response late");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending");
   a_xfd_clear: assert property (s_st_take |=> !s_axi_rdata[15])
      else $error("status bit 15 set");
   a_xhd_clear: assert property (s_st_take |=> !s_axi_rdata[14])
      else $error("status bit 14 set");
   a_tfd_set: assert property (s_st_take |=> s_axi_rdata[13] && s_axi_rdata[12] == T_HD_CAP)
      else $error("status bits 13 or 12 wrong");
   a_unmapped_err: assert property (s_rd_take ##0 (s_axi_araddr != 8'h34 && s_axi_araddr != 8'h38
      && s_axi_araddr != 8'h3c) |=> s_axi_rresp == pmia_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule
bind pmia_regs pmia_regs_monitor #(.T_HD_CAP(T_HD_CAP)) u_monitor (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);

// ==== dv/pmia_regs_test.sv ====
`timescale 1ns/1ps
module pmia_regs_test;
   logic        aclk = 1'b0;
   logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r, st;
   logic [15:0] d, wd, ctrl_m, tgt;
   logic [15:0] mem [32];
   logic [4:0]  i;
   logic [7:0]  bad_a [3];
   int          op;
   int          fail_count = 0;
   int          cmp_count = 0;

   pmia_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   always #12.5 aclk = ~aclk;

   // ************************************************************
   // bus tasks and comparison
   // ************************************************************
   task chk(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task report_and_stop;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // upper lanes carry noise; the block must ignore them
   task wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] sb);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'($urandom), v};
      s_axi_wstrb <= {2'($urandom), sb};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      if (n >= 50) fail_count++;
   endtask

   task rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      {r, d} = {s_axi_rresp, s_axi_rdata[15:0]};
      if (n >= 50) fail_count++;
      chk({18'h0, s_axi_rdata[31:16]}, 34'h0);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      void'($urandom(43431));
      foreach (mem[k]) mem[k] = 16'h0;
      bad_a = '{8'h40, 8'h35, 8'h00};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h34); chk({r, 16'h0, d}, 34'h0);
      rd(8'h38); chk({r, 16'h0, d}, 34'h0);
      wr(8'h3c, 16'hffff, 2'h3); chk({r, 32'h0}, 34'h0);
      rd(8'h3c); chk({r, 16'h0, d}, 34'h2000);
      foreach (bad_a[k]) begin
         rd(bad_a[k]); chk({r, 16'h0, d}, {pmia_pkg::RESP_SLVERR, 32'h0});
         wr(bad_a[k], 16'h1234, 2'h3); chk({r, 32'h0}, {pmia_pkg::RESP_SLVERR, 32'h0});
      end
      for (op = 1; op < 4; op++) repeat (2) begin
         ctrl_m = {2'h0, 14'($urandom)};
         tgt = (op == 2) ? 16'hfffe : 16'($urandom);
         wr(8'h34, ctrl_m, 2'h3);
         rd(8'h34); chk({r, 16'h0, d}, {18'h0, ctrl_m});
         wr(8'h38, tgt, 2'h3);
         ctrl_m[15:14] = 2'(op);
         wr(8'h34, ctrl_m, 2'h3);
         repeat (6) begin
            i = {ctrl_m[1:0], tgt[2:0]};
            if ($urandom % 2) begin
               st = 2'($urandom);
               wd = 16'($urandom);
               wr(8'h38, wd, st);
               if (st[0]) mem[i][7:0] = wd[7:0];
               if (st[1]) mem[i][15:8] = wd[15:8];
               if (op >= 2) tgt++;
            end else begin
               rd(8'h38); chk({r, 16'h0, d}, {18'h0, mem[i]});
               if (op == 2) tgt++;
            end
         end
         ctrl_m[15:14] = 2'h0;
         wr(8'h34, ctrl_m, 2'h3);
         rd(8'h38); chk({r, 16'h0, d}, {18'h0, tgt});
      end
      // second reset in mid-run must bring the control word back to zero
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h34); chk({r, 16'h0, d}, 34'h0);
      rd(8'h38); chk({r, 16'h0, d}, 34'h0);
      report_and_stop;
   end

   initial begin
      repeat (5000) @(posedge aclk);
      fail_count++;
      report_and_stop;
   end
endmodule
